// >>> sbc_brake_check.sv
// Safe brake check sequencer: request handling, test sequence, motion watch and status.
// Assumes all inputs are synchronous to mclk_in and the configuration inputs are static.
`timescale 1ns/1ps

// Notes on behaviour
// - A new input request or bus request launches the brake test.
// - The bus request starts a test only on its low-to-high transition.
// - State reads 00h whenever no test is running.
// - State 01h enables the power stage.
// - State 02h ramps current toward the positive test force.
// - State 03h shows the positive test current has been reached.
// - State 04h ramps current toward the negative test force.
// - State 05h shows the negative test current has been reached.
// - State 06h returns the current to zero.
// - Torque-off activity appears in bit 0 of both safety status words.
// - Position deviation beyond the limit in states 02h to 05h flags failure.
// - Starting with no brake configured raises brake test failed.
// - The interval-elapsed flag is set after every power up.
// - A passed test clears the flag; it returns after the interval.
// - A test only starts in the ready-to-switch-on main state.
// - Test force is held for the apply time; motion limit judges pass.
// - The test-running flag stays up throughout the sequence.
module sbc_brake_check #(
	parameter int TICK_CYCLES = sbc_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Parameter access port of the realtime bus interface.
	input  wire logic [15:0]        reg_addr_in,
	input  wire logic               reg_write_in,
	input  wire logic [7:0]         reg_wdata_in,
	output logic [7:0]              reg_rdata_out,
	// Digital input connector and its request function selection.
	input  wire logic [3:0]         digital_input_connector_in,
	input  wire logic [3:0]         request_function_select_in,
	// Drive configuration and state.
	input  wire logic               brake_configured_in,
	input  wire logic               motor_configured_in,
	input  wire logic               ready_to_switch_on_in,
	input  wire logic               torque_off_active_in,
	// Test parameters.
	input  wire logic signed [15:0] test_current_in,
	input  wire logic [31:0]        apply_time_ticks_in,
	input  wire logic [31:0]        motion_limit_in,
	input  wire logic [31:0]        request_interval_ticks_in,
	// Motor position feedback.
	input  wire logic signed [31:0] position_in,
	// Drive outputs.
	output logic                    power_stage_enable_out,
	output logic signed [15:0]      current_setpoint_out,
	// Status.
	output logic [7:0]              brake_test_state_out,
	output logic                    test_running_out,
	output logic                    test_failed_out,
	output logic                    interval_elapsed_out,
	output logic                    safety_status_word_one_out,
	output logic                    fsoe_status_word_out
);
	sbc_pkg::sbc_state_t state;
	sbc_pkg::sbc_state_t next_state;

	logic               bus_request;
	logic               bus_request_prev;
	logic               input_request;
	logic               input_request_prev;
	logic [3:0]         input_hits;
	logic               start_request;
	logic               start_ok;
	logic               start_refused;
	logic [31:0]        tick_count;
	logic               tick;
	logic [31:0]        settle_count;
	logic [31:0]        apply_prescale;
	logic [31:0]        apply_count;
	logic signed [15:0] ramp_target;
	logic               at_target;
	logic signed [31:0] ref_position;
	logic signed [32:0] deviation;
	logic [32:0]        abs_deviation;
	logic               motion_fault;
	logic               watching;
	logic               test_passed;
	logic               interval_restart;

	// Request sources: a connector input counts only where the request function is selected on it.
	for (genvar i = 0; i < $bits(digital_input_connector_in); i++) begin : g_input_hit
		assign input_hits[i] = digital_input_connector_in[i] && request_function_select_in[i];
	end
	assign input_request = |input_hits;
	assign start_request = (input_request && !input_request_prev)
		|| (bus_request && !bus_request_prev);
	assign start_ok      = start_request && ready_to_switch_on_in
		&& motor_configured_in && brake_configured_in && (state == sbc_pkg::SBC_IDLE);
	assign start_refused = start_request && ready_to_switch_on_in
		&& !brake_configured_in && (state == sbc_pkg::SBC_IDLE);

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			input_request_prev <= 1'b0;
			bus_request_prev   <= sbc_pkg::BUS_REQUEST_RESET;
		end else begin
			input_request_prev <= input_request;
			bus_request_prev   <= bus_request;
		end
	end

	// Bus-written request variable.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			bus_request <= sbc_pkg::BUS_REQUEST_RESET;
		end else if (reg_write_in && reg_addr_in == sbc_pkg::ID_BUS_REQUEST) begin
			bus_request <= reg_wdata_in[0];
		end
	end

	// Register read port.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= sbc_pkg::READ_DATA_RESET;
		end else begin
			unique case (reg_addr_in)
				sbc_pkg::ID_INTERVAL_ELAPSED: reg_rdata_out <= {7'h00, interval_elapsed_out};
				sbc_pkg::ID_TEST_RUNNING:     reg_rdata_out <= {7'h00, test_running_out};
				sbc_pkg::ID_TEST_FAILED:      reg_rdata_out <= {7'h00, test_failed_out};
				sbc_pkg::ID_BRAKE_TEST_STATE: reg_rdata_out <= brake_test_state_out;
				sbc_pkg::ID_INPUT_REQUEST:    reg_rdata_out <= {7'h00, input_request};
				sbc_pkg::ID_BUS_REQUEST:      reg_rdata_out <= {7'h00, bus_request};
				default:                      reg_rdata_out <= sbc_pkg::READ_DATA_RESET;
			endcase
		end
	end

	// Time base tick for the request interval.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tick_count <= '0;
		end else if (tick_count >= 32'(TICK_CYCLES - 1)) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 32'h00000001;
		end
	end
	assign tick = (tick_count >= 32'(TICK_CYCLES - 1));

	// Power stage settle counter while in the enable state.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			settle_count <= '0;
		end else if (state == sbc_pkg::SBC_ENABLE_POWER) begin
			settle_count <= settle_count + 32'h00000001;
		end else begin
			settle_count <= '0;
		end
	end

	// Apply time counter with its own prescaler, restarted in each applied state so that
	// the free-running tick cannot cut the first tick of the hold short.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			apply_prescale <= '0;
			apply_count    <= '0;
		end else if (state == sbc_pkg::SBC_POS_APPLIED || state == sbc_pkg::SBC_NEG_APPLIED) begin
			if (apply_prescale >= 32'(TICK_CYCLES - 1)) begin
				apply_prescale <= '0;
				apply_count    <= apply_count + 32'h00000001;
			end else begin
				apply_prescale <= apply_prescale + 32'h00000001;
			end
		end else begin
			apply_prescale <= '0;
			apply_count    <= '0;
		end
	end

	// Motion watch against the position captured when current is first applied.
	assign watching      = (state == sbc_pkg::SBC_SET_POS) || (state == sbc_pkg::SBC_POS_APPLIED)
		|| (state == sbc_pkg::SBC_SET_NEG) || (state == sbc_pkg::SBC_NEG_APPLIED);
	assign deviation     = 33'(position_in) - 33'(ref_position);
	assign abs_deviation = deviation[32] ? 33'(-deviation) : 33'(deviation);
	assign motion_fault  = watching && (abs_deviation > 33'(motion_limit_in));

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ref_position <= '0;
		end else if (state == sbc_pkg::SBC_ENABLE_POWER) begin
			ref_position <= position_in;
		end
	end

	// Sequence.
	always_comb begin
		next_state = state;
		unique case (state)
			sbc_pkg::SBC_IDLE: begin
				if (start_ok) begin
					next_state = sbc_pkg::SBC_ENABLE_POWER;
				end
			end
			sbc_pkg::SBC_ENABLE_POWER: begin
				if (settle_count >= 32'(sbc_pkg::ENABLE_SETTLE_CYCLES - 1)) begin
					next_state = sbc_pkg::SBC_SET_POS;
				end
			end
			sbc_pkg::SBC_SET_POS: begin
				if (motion_fault) begin
					next_state = sbc_pkg::SBC_RESET_CUR;
				end else if (at_target) begin
					next_state = sbc_pkg::SBC_POS_APPLIED;
				end
			end
			sbc_pkg::SBC_POS_APPLIED: begin
				if (motion_fault) begin
					next_state = sbc_pkg::SBC_RESET_CUR;
				end else if (apply_count >= apply_time_ticks_in) begin
					next_state = sbc_pkg::SBC_SET_NEG;
				end
			end
			sbc_pkg::SBC_SET_NEG: begin
				if (motion_fault) begin
					next_state = sbc_pkg::SBC_RESET_CUR;
				end else if (at_target) begin
					next_state = sbc_pkg::SBC_NEG_APPLIED;
				end
			end
			sbc_pkg::SBC_NEG_APPLIED: begin
				if (motion_fault || apply_count >= apply_time_ticks_in) begin
					next_state = sbc_pkg::SBC_RESET_CUR;
				end
			end
			sbc_pkg::SBC_RESET_CUR: begin
				if (at_target) begin
					next_state = sbc_pkg::SBC_IDLE;
				end
			end
			default: begin
				next_state = sbc_pkg::SBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state <= sbc_pkg::SBC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Current target per state.
	always_comb begin
		unique case (state)
			sbc_pkg::SBC_SET_POS, sbc_pkg::SBC_POS_APPLIED: ramp_target = test_current_in;
			sbc_pkg::SBC_SET_NEG, sbc_pkg::SBC_NEG_APPLIED: ramp_target = 16'(-test_current_in);
			default:                                        ramp_target = '0;
		endcase
	end

	sbc_current_ramp u_ramp (
		.mclk_in       (mclk_in),
		.reset_in      (reset_in),
		.target_in     (ramp_target),
		.setpoint_out  (current_setpoint_out),
		.at_target_out (at_target)
	);

	// Power stage stays on from the enable state until the current is back at zero.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			power_stage_enable_out <= 1'b0;
		end else begin
			power_stage_enable_out <= (next_state != sbc_pkg::SBC_IDLE);
		end
	end

	// Reported state code.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			brake_test_state_out <= sbc_pkg::CODE_IDLE;
		end else begin
			unique case (next_state)
				sbc_pkg::SBC_IDLE:         brake_test_state_out <= sbc_pkg::CODE_IDLE;
				sbc_pkg::SBC_ENABLE_POWER: brake_test_state_out <= sbc_pkg::CODE_ENABLE_POWER;
				sbc_pkg::SBC_SET_POS:      brake_test_state_out <= sbc_pkg::CODE_SET_POS;
				sbc_pkg::SBC_POS_APPLIED:  brake_test_state_out <= sbc_pkg::CODE_POS_APPLIED;
				sbc_pkg::SBC_SET_NEG:      brake_test_state_out <= sbc_pkg::CODE_SET_NEG;
				sbc_pkg::SBC_NEG_APPLIED:  brake_test_state_out <= sbc_pkg::CODE_NEG_APPLIED;
				sbc_pkg::SBC_RESET_CUR:    brake_test_state_out <= sbc_pkg::CODE_RESET_CUR;
				default:                   brake_test_state_out <= sbc_pkg::CODE_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			test_running_out <= 1'b0;
		end else begin
			test_running_out <= (next_state != sbc_pkg::SBC_IDLE);
		end
	end

	// Failure is sticky until the next accepted start; a refused start sets it again.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			test_failed_out <= 1'b0;
		end else if (motion_fault || start_refused) begin
			test_failed_out <= 1'b1;
		end else if (start_ok) begin
			test_failed_out <= 1'b0;
		end
	end

	// A run that completes both directions without a motion fault passes.
	assign test_passed      = (state == sbc_pkg::SBC_NEG_APPLIED) && !motion_fault
		&& (apply_count >= apply_time_ticks_in);
	assign interval_restart = test_passed;

	sbc_interval_timer u_interval (
		.mclk_in           (mclk_in),
		.reset_in          (reset_in),
		.tick_in           (tick),
		.restart_in        (interval_restart),
		.interval_ticks_in (request_interval_ticks_in),
		.elapsed_out       (interval_elapsed_out)
	);

	// Torque-off activity mirrored into both safety status words.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			safety_status_word_one_out <= 1'b0;
			fsoe_status_word_out       <= 1'b0;
		end else begin
			safety_status_word_one_out <= torque_off_active_in;
			fsoe_status_word_out       <= torque_off_active_in;
		end
	end
endmodule

// >>> sbc_pkg.sv
// Shared constants for the safe brake check sequencer.
// Assumes a 200 MHz system clock and parameter-number register access.
package sbc_pkg;

	// Clock and time base.
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES    = (TICK_PERIOD_US * 1000 * 1000) / CLK_PERIOD_PS;

	// Power stage settling time before current is driven.
	localparam int ENABLE_SETTLE_NS     = 2000;
	localparam int ENABLE_SETTLE_CYCLES = (ENABLE_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Register identifiers on the parameter access port.
	localparam logic [15:0] ID_INTERVAL_ELAPSED = 16'h1A21;
	localparam logic [15:0] ID_TEST_RUNNING     = 16'h1A22;
	localparam logic [15:0] ID_TEST_FAILED      = 16'h1A23;
	localparam logic [15:0] ID_BRAKE_TEST_STATE = 16'h1A42;
	localparam logic [15:0] ID_INPUT_REQUEST    = 16'h1A60;
	localparam logic [15:0] ID_BUS_REQUEST      = 16'h1A61;

	// Reset values.
	localparam logic       BUS_REQUEST_RESET       = 1'h0;
	localparam logic       INTERVAL_ELAPSED_RESET  = 1'h1;
	localparam logic [7:0] READ_DATA_RESET         = 8'h00;

	// Brake test state codes as reported to software.
	localparam logic [7:0] CODE_IDLE         = 8'h00;
	localparam logic [7:0] CODE_ENABLE_POWER = 8'h01;
	localparam logic [7:0] CODE_SET_POS      = 8'h02;
	localparam logic [7:0] CODE_POS_APPLIED  = 8'h03;
	localparam logic [7:0] CODE_SET_NEG      = 8'h04;
	localparam logic [7:0] CODE_NEG_APPLIED  = 8'h05;
	localparam logic [7:0] CODE_RESET_CUR    = 8'h06;

	// Bit position of torque-off activity in both safety status words.
	localparam int STATUS_TORQUE_OFF_BIT = 0;

	// Current ramp step per clock, in setpoint units.
	localparam logic [15:0] RAMP_STEP = 16'h0010;

	typedef enum logic [2:0] {
		SBC_IDLE,
		SBC_ENABLE_POWER,
		SBC_SET_POS,
		SBC_POS_APPLIED,
		SBC_SET_NEG,
		SBC_NEG_APPLIED,
		SBC_RESET_CUR
	} sbc_state_t;

endpackage

// >>> sbc_current_ramp.sv
// Slew-limited current setpoint generator.
// Assumes the target is held stable while a ramp is in progress.
`timescale 1ns/1ps
module sbc_current_ramp (
	// Clock and reset.
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Target and result.
	input  wire logic signed [15:0] target_in,
	output logic signed [15:0]      setpoint_out,
	output logic                    at_target_out
);
	logic signed [15:0] step;
	logic signed [15:0] diff;
	logic signed [16:0] wide_diff;

	assign step          = sbc_pkg::RAMP_STEP;
	assign wide_diff     = 17'(target_in) - 17'(setpoint_out);
	assign diff          = 16'(wide_diff);
	assign at_target_out = (setpoint_out == target_in);

	// The setpoint moves by at most one step per clock so the current never jumps.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			setpoint_out <= '0;
		end else if (wide_diff > 17'(step)) begin
			setpoint_out <= 16'(setpoint_out + step);
		end else if (wide_diff < -17'(step)) begin
			setpoint_out <= 16'(setpoint_out - step);
		end else begin
			setpoint_out <= setpoint_out + diff;
		end
	end
endmodule

// >>> sbc_interval_timer.sv
// Test interval timer that raises the interval-elapsed flag.
// Assumes a one-cycle time base tick and a one-cycle restart pulse.
`timescale 1ns/1ps
module sbc_interval_timer (
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	// Control.
	input  wire logic        tick_in,
	input  wire logic        restart_in,
	input  wire logic [31:0] interval_ticks_in,
	// Status.
	output logic             elapsed_out
);
	logic [31:0] count;

	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			count <= '0;
		end else if (restart_in) begin
			count <= '0;
		end else if (tick_in && !elapsed_out) begin
			count <= count + 32'h00000001;
		end
	end

	// The flag comes up at power on and stays up until a passed test restarts timing.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			elapsed_out <= sbc_pkg::INTERVAL_ELAPSED_RESET;
		end else if (restart_in) begin
			elapsed_out <= 1'b0;
		end else if (count >= interval_ticks_in) begin
			elapsed_out <= 1'b1;
		end
	end
endmodule

// >>> sbc_brake_check_checker.sv
// Port-level checks of the safe brake check sequencer.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module sbc_brake_check_checker #(
	parameter int TICK_CYCLES = 4
) (
	// Clock and reset.
	input wire logic               mclk_in,
	input wire logic               reset_in,
	// Request and drive inputs.
	input wire logic [3:0]         digital_input_connector_in,
	input wire logic [3:0]         request_function_select_in,
	input wire logic               brake_configured_in,
	input wire logic               motor_configured_in,
	input wire logic               ready_to_switch_on_in,
	input wire logic               torque_off_active_in,
	input wire logic signed [15:0] test_current_in,
	// Outputs under watch.
	input wire logic               power_stage_enable_out,
	input wire logic signed [15:0] current_setpoint_out,
	input wire logic [7:0]         brake_test_state_out,
	input wire logic               test_running_out,
	input wire logic               test_failed_out,
	input wire logic               interval_elapsed_out,
	input wire logic               safety_status_word_one_out,
	input wire logic               fsoe_status_word_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (reset_in);

	running_flag_a: assert property (test_running_out == (brake_test_state_out != 8'h00))
		else $error("running flag disagrees with state");
	power_enable_a: assert property (brake_test_state_out == 8'h01 |-> power_stage_enable_out)
		else $error("power stage off in enable state");
	pos_reached_a: assert property (brake_test_state_out == 8'h03 |-> current_setpoint_out == test_current_in)
		else $error("positive current not at target");
	neg_reached_a: assert property (brake_test_state_out == 8'h05 |-> current_setpoint_out == -test_current_in)
		else $error("negative current not at target");
	torque_off_word_a: assert property (safety_status_word_one_out == $past(torque_off_active_in)
		&& fsoe_status_word_out == $past(torque_off_active_in)) else $error("torque-off status bit wrong");
	input_launch_a: assert property (brake_test_state_out == 8'h00 && ready_to_switch_on_in && motor_configured_in
		&& brake_configured_in && $rose(|(digital_input_connector_in & request_function_select_in))
		|-> ##[1:2] brake_test_state_out == 8'h01) else $error("input request did not launch");
	no_brake_fail_a: assert property (brake_test_state_out == 8'h00 && ready_to_switch_on_in && motor_configured_in
		&& !brake_configured_in && $rose(|(digital_input_connector_in & request_function_select_in))
		|-> ##[1:2] test_failed_out) else $error("missing brake not flagged");
	not_ready_a: assert property (brake_test_state_out == 8'h00 && !ready_to_switch_on_in
		|=> brake_test_state_out == 8'h00) else $error("test left idle while not ready");
	reset_cur_exit_a: assert property (brake_test_state_out == 8'h06 && current_setpoint_out == 16'sh0000
		|-> ##[1:2] brake_test_state_out == 8'h00) else $error("no return to idle");
	pass_clears_a: assert property (brake_test_state_out == 8'h05 ##1 (brake_test_state_out == 8'h06
		&& !test_failed_out) |-> ##[0:1] !interval_elapsed_out) else $error("pass kept interval flag");
endmodule

bind sbc_brake_check sbc_brake_check_checker #(.TICK_CYCLES(TICK_CYCLES)) i_checker (
	.mclk_in(mclk_in), .reset_in(reset_in),
	.digital_input_connector_in(digital_input_connector_in), .request_function_select_in(request_function_select_in),
	.brake_configured_in(brake_configured_in), .motor_configured_in(motor_configured_in),
	.ready_to_switch_on_in(ready_to_switch_on_in), .torque_off_active_in(torque_off_active_in),
	.test_current_in(test_current_in), .power_stage_enable_out(power_stage_enable_out),
	.current_setpoint_out(current_setpoint_out), .brake_test_state_out(brake_test_state_out),
	.test_running_out(test_running_out), .test_failed_out(test_failed_out),
	.interval_elapsed_out(interval_elapsed_out), .safety_status_word_one_out(safety_status_word_one_out),
	.fsoe_status_word_out(fsoe_status_word_out)
);

// >>> sbc_motor_model.sv
// Motor shaft behind a holding brake, for the brake check bench.
// Assumes enable and setpoint come from the sequencer under test.
`timescale 1ns/1ps
module sbc_motor_model (
	// Clock and reset.
	input  wire logic               mclk_in,
	input  wire logic               reset_in,
	// Drive side and brake condition.
	input  wire logic               power_stage_enable_in,
	input  wire logic signed [15:0] current_setpoint_in,
	input  wire logic               brake_slips_in,
	// Feedback.
	output logic signed [31:0]      position_out
);
	// A worn brake lets the shaft creep with the applied current; a good one holds it.
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			position_out <= 32'sh0000_1000;
		end else if (power_stage_enable_in && brake_slips_in) begin
			position_out <= position_out + 32'(current_setpoint_in);
		end
	end
endmodule

// >>> sbc_brake_check_tb_top.sv
// Self-checking bench of the brake check sequencer.
// Assumes the sequencer package and the motor model are compiled first.
`timescale 1ns/1ps
module sbc_brake_check_tb_top;
	localparam int                 TICKS    = 4;
	localparam logic signed [15:0] TEST_CUR = 16'sh0040;
	logic               mclk_in;
	logic               reset_in;
	logic [15:0]        reg_addr_in;
	logic               reg_write_in;
	logic [7:0]         reg_wdata_in;
	logic [7:0]         rdata;
	logic [3:0]         din;
	logic               brake_cfg;
	logic               motor_cfg;
	logic               ready;
	logic               torque_off;
	logic               slips;
	logic signed [31:0] position;
	logic               power;
	logic signed [15:0] setpoint;
	logic [7:0]         state;
	logic               running;
	logic               failed;
	logic               elapsed;
	logic               sw_one;
	logic               sw_fsoe;
	int                 miscompares;
	int                 checked;
	int                 n;

	sbc_brake_check #(.TICK_CYCLES(TICKS)) i_dut (
		.mclk_in(mclk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .digital_input_connector_in(din),
		.request_function_select_in(4'h4), .brake_configured_in(brake_cfg), .motor_configured_in(motor_cfg),
		.ready_to_switch_on_in(ready), .torque_off_active_in(torque_off), .test_current_in(TEST_CUR),
		.apply_time_ticks_in(32'h0000_0002), .motion_limit_in(32'h0000_0100),
		.request_interval_ticks_in(32'h0000_0005), .position_in(position), .power_stage_enable_out(power),
		.current_setpoint_out(setpoint), .brake_test_state_out(state), .test_running_out(running),
		.test_failed_out(failed), .interval_elapsed_out(elapsed), .safety_status_word_one_out(sw_one),
		.fsoe_status_word_out(sw_fsoe)
	);
	sbc_motor_model i_motor (
		.mclk_in(mclk_in), .reset_in(reset_in), .power_stage_enable_in(power),
		.current_setpoint_in(setpoint), .brake_slips_in(slips), .position_out(position)
	);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [15:0] addr, input logic [7:0] data);
		@(posedge mclk_in);
		reg_addr_in  <= addr;
		reg_write_in <= 1'b1;
		reg_wdata_in <= data;
		@(posedge mclk_in);
		reg_write_in <= 1'b0;
	endtask
	task automatic reg_chk(input logic [15:0] addr, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_addr_in <= addr;
		@(posedge mclk_in);
		#1;
		check(16'(rdata), 16'(exp));
	endtask
	task automatic wait_state(input logic [7:0] code, input int limit);
		n = 0;
		while (state !== code && n < limit) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		check(16'(state), 16'(code));
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	initial begin
		repeat (8000) @(posedge mclk_in);
		miscompares++;
		complete_run;
	end

	initial begin
		miscompares = 0;
		checked = 0;
		reset_in = 1'b1;
		reg_addr_in = 16'h0000;
		reg_write_in = 1'b0;
		reg_wdata_in = 8'h00;
		din = 4'h0;
		brake_cfg = 1'b1;
		motor_cfg = 1'b1;
		ready = 1'b0;
		torque_off = 1'b0;
		slips = 1'b0;
		repeat (4) @(posedge mclk_in);
		reset_in <= 1'b0;
		reg_chk(sbc_pkg::ID_INTERVAL_ELAPSED, 8'h01);
		reg_chk(16'h1234, 8'h00);
		reg_wr(sbc_pkg::ID_BRAKE_TEST_STATE, 8'h05);
		reg_chk(sbc_pkg::ID_BRAKE_TEST_STATE, sbc_pkg::CODE_IDLE);
		@(posedge mclk_in);
		torque_off <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		check(16'(sw_one), 16'h1);
		check(16'(sw_fsoe), 16'h1);
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h01);
		torque_off <= 1'b0;
		reg_chk(sbc_pkg::ID_BUS_REQUEST, 8'h01);
		repeat (4) @(posedge mclk_in);
		#1;
		check(16'(state), 16'(sbc_pkg::CODE_IDLE));
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h00);
		ready <= 1'b1;
		motor_cfg <= 1'b0;
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h01);
		repeat (4) @(posedge mclk_in);
		#1;
		check(16'(state), 16'(sbc_pkg::CODE_IDLE));
		check(16'(failed), 16'h0);
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h00);
		motor_cfg <= 1'b1;
		// The test current stands for about 1.3 times a load of 0x31.
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h01);
		wait_state(sbc_pkg::CODE_ENABLE_POWER, 4);
		check(16'(power), 16'h1);
		check(16'(running), 16'h1);
		reg_chk(sbc_pkg::ID_TEST_RUNNING, 8'h01);
		wait_state(sbc_pkg::CODE_SET_POS, sbc_pkg::ENABLE_SETTLE_CYCLES + 4);
		wait_state(sbc_pkg::CODE_POS_APPLIED, 12);
		check(setpoint, TEST_CUR);
		wait_state(sbc_pkg::CODE_SET_NEG, 4 * TICKS + 4);
		// An apply time of two ticks holds the positive current for at least two full ticks.
		check(16'(n >= 2 * TICKS), 16'h1);
		wait_state(sbc_pkg::CODE_NEG_APPLIED, 16);
		check(setpoint, -TEST_CUR);
		wait_state(sbc_pkg::CODE_RESET_CUR, 4 * TICKS + 4);
		wait_state(sbc_pkg::CODE_IDLE, 12);
		check(16'(failed), 16'h0);
		check(16'(elapsed), 16'h0);
		repeat (8) @(posedge mclk_in);
		#1;
		check(16'(state), 16'(sbc_pkg::CODE_IDLE));
		wait (elapsed === 1'b1 || n > 9999);
		reg_chk(sbc_pkg::ID_INTERVAL_ELAPSED, 8'h01);
		reg_wr(sbc_pkg::ID_BUS_REQUEST, 8'h00);
		brake_cfg <= 1'b0;
		din <= 4'h4;
		repeat (3) @(posedge mclk_in);
		#1;
		check(16'(failed), 16'h1);
		check(16'(state), 16'(sbc_pkg::CODE_IDLE));
		reg_chk(sbc_pkg::ID_INPUT_REQUEST, 8'h01);
		@(posedge mclk_in);
		din <= 4'h0;
		brake_cfg <= 1'b1;
		slips <= 1'b1;
		@(posedge mclk_in);
		din <= 4'h4;
		wait_state(sbc_pkg::CODE_ENABLE_POWER, 4);
		check(16'(failed), 16'h0);
		wait_state(sbc_pkg::CODE_RESET_CUR, 600);
		check(16'(failed), 16'h1);
		wait_state(sbc_pkg::CODE_IDLE, 12);
		reg_chk(sbc_pkg::ID_TEST_FAILED, 8'h01);
		complete_run;
	end
endmodule
